// ==== include/srxf_map.svh ====
`ifndef SRXF_MAP_SVH
`define SRXF_MAP_SVH
// Register byte offsets
`define SRXF_ADR_STAT 8'h00
`define SRXF_ADR_DATA 8'h04
`define SRXF_ADR_CTRL 8'h08
`define SRXF_ADR_CNT 8'h0C
`define SRXF_ADR_BDIV 8'h10
`define SRXF_ADR_ISTS 8'h14
`define SRXF_ADR_IMSK 8'h18
// Status field positions
`define SRXF_ST_PER 2
`define SRXF_ST_RDF 1
`define SRXF_ST_DR 0
// Control field positions
`define SRXF_CT_SYNC 0
`define SRXF_CT_PEN 1
`define SRXF_CT_PODD 2
`define SRXF_CT_TRG_LO 4
`define SRXF_CT_TRG_HI 5
// Interrupt field positions
`define SRXF_IRQ_RDF 0
`define SRXF_IRQ_DR 1
`define SRXF_IRQ_PER 2
`define SRXF_IRQ_OVR 3
// Reset values
`define SRXF_CTRL_RST 6'h00
`define SRXF_BDIV_RST 16'h0010
// Receive trigger levels by select code
`define SRXF_TRG0 5'h01
`define SRXF_TRG1 5'h04
`define SRXF_TRG2 5'h08
`define SRXF_TRG3 5'h0E
// Idle timeout in bit time units
`define SRXF_DR_ETU 4'hF
// Receive FIFO size
`define SRXF_FIFO_DEPTH 5'h10
`endif

// ==== include/srxf_pkg.sv ====
package srxf_pkg;
  typedef logic [7:0] srxf_byte_t;
  typedef enum logic [2:0] {
    SRXF_IDLE = 3'h0,
    SRXF_START = 3'h1,
    SRXF_DATA = 3'h3,
    SRXF_PAR = 3'h2,
    SRXF_STOP = 3'h6
  } srxf_rx_state_t;
endpackage

// ==== logic/srxf_fifo.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "srxf_map.svh"
module srxf_fifo (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Write side
  input wire logic push_in,
  input wire logic [8:0] wdata_in,
  // Read side
  input wire logic pop_in,
  output logic [8:0] head_out,
  output logic [4:0] count_out,
  output logic ovr_out
);
  logic [8:0] mem_ff [16];
  logic [3:0] wp_ff, rp_ff;
  logic [4:0] cnt_ff;
  wire full = (cnt_ff == `SRXF_FIFO_DEPTH);
  wire empty = (cnt_ff == 5'h00);
  wire do_push = push_in & ~full;
  wire do_pop = pop_in & ~empty;
  // Pointers and fill count
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wp_ff <= 4'h0;
      rp_ff <= 4'h0;
      cnt_ff <= 5'h00;
    end else begin
      wp_ff <= wp_ff + {3'h0, do_push};
      rp_ff <= rp_ff + {3'h0, do_pop};
      cnt_ff <= cnt_ff + {4'h0, do_push} - {4'h0, do_pop};
    end
  end
  // Storage, no reset needed
  always_ff @(posedge clk_in) begin
    if (do_push) mem_ff[wp_ff] <= wdata_in;
  end
  assign head_out = mem_ff[rp_ff];
  assign count_out = cnt_ff;
  assign ovr_out = push_in & full; // Word lost
endmodule // srxf_fifo
`default_nettype wire

// ==== logic/srxf_rx.sv ====
`timescale 1ns/1ps
`default_nettype none
module srxf_rx (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Synchronised line and clock
  input wire logic rxd_in,
  input wire logic sck_in,
  // Configuration
  input wire logic sync_mode_in,
  input wire logic par_en_in,
  input wire logic par_odd_in,
  input wire logic [15:0] bit_div_in,
  // Received word
  output logic word_vld_out,
  output srxf_pkg::srxf_byte_t word_out,
  output logic perr_out,
  // Line events
  output logic start_out,
  output logic stop_out
);
  import srxf_pkg::*;
  srxf_rx_state_t state_ff;
  logic [15:0] cnt_ff;
  logic [2:0] bit_ff;
  srxf_byte_t shf_ff;
  logic perr_ff, vld_ff, start_ff, stop_ff, rxd_d_ff, sck_d_ff;
  wire fall = rxd_d_ff & ~rxd_in;
  wire sck_rise = sck_in & ~sck_d_ff;
  wire tick = (cnt_ff == 16'h0000);
  wire par_bad = (^shf_ff) ^ rxd_in ^ par_odd_in;
  // Frame sequencer, async or clocked
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_ff <= SRXF_IDLE;
      cnt_ff <= 16'h0000;
      bit_ff <= 3'h0;
      shf_ff <= 8'h00;
      perr_ff <= 1'b0;
      vld_ff <= 1'b0;
      start_ff <= 1'b0;
      stop_ff <= 1'b0;
      rxd_d_ff <= 1'b1;
      sck_d_ff <= 1'b0;
    end else begin
      rxd_d_ff <= rxd_in;
      sck_d_ff <= sck_in;
      vld_ff <= 1'b0;
      start_ff <= 1'b0;
      stop_ff <= 1'b0;
      cnt_ff <= tick ? bit_div_in : cnt_ff - 16'h0001;
      if (sync_mode_in) begin
        state_ff <= SRXF_IDLE;
        perr_ff <= 1'b0;
        if (sck_rise) begin
          shf_ff <= {rxd_in, shf_ff[7:1]};
          bit_ff <= bit_ff + 3'h1;
          vld_ff <= (bit_ff == 3'h7);
        end
      end else begin
        unique case (state_ff)
          SRXF_IDLE: begin
            bit_ff <= 3'h0;
            if (fall) begin
              state_ff <= SRXF_START;
              cnt_ff <= {1'b0, bit_div_in[15:1]};
              start_ff <= 1'b1;
            end
          end
          SRXF_START: if (tick) begin
            state_ff <= rxd_in ? SRXF_IDLE : SRXF_DATA;
            perr_ff <= 1'b0;
          end
          SRXF_DATA: if (tick) begin
            shf_ff <= {rxd_in, shf_ff[7:1]};
            bit_ff <= bit_ff + 3'h1;
            if (bit_ff == 3'h7) state_ff <= par_en_in ? SRXF_PAR : SRXF_STOP;
          end
          SRXF_PAR: if (tick) begin
            perr_ff <= par_bad;
            state_ff <= SRXF_STOP;
          end
          SRXF_STOP: if (tick) begin
            vld_ff <= 1'b1;
            stop_ff <= 1'b1;
            state_ff <= SRXF_IDLE;
          end
          default: state_ff <= SRXF_IDLE;
        endcase
      end
    end
  end
  assign word_vld_out = vld_ff;
  assign word_out = shf_ff;
  assign perr_out = perr_ff;
  assign start_out = start_ff;
  assign stop_out = stop_ff;
endmodule // srxf_rx
`default_nettype wire

// ==== logic/srxf_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "srxf_map.svh"
// Function
// RULE_01: In async mode the parity flag reads 1 while the FIFO head word has a parity error.
// RULE_02: The parity flag reads 0 while the FIFO head word has no parity error.
// RULE_03: Reset forces the parity, above-trigger and data-ready flags to 0.
// RULE_04: The above-trigger flag sets when the FIFO fill count exceeds the selected trigger.
// RULE_05: The above-trigger flag clears only after read as 1, write 0, then drain below trigger.
// RULE_06: The FIFO holds 16 words and a read of an empty FIFO gives undefined data.
// RULE_07: The count register shows the FIFO fill count in its low 8 bits.
// RULE_08: In async mode data-ready sets when fill is below trigger and 15 bit times pass idle.
// RULE_09: In clocked mode data-ready never sets.
// RULE_10: Data-ready clears only after read as 1, write 0, then drain of every word.
// RULE_11: Writing 0 requests a clear of a clearable flag and writing 1 sets nothing.
// RULE_12: The idle interval counts bit periods from each stop bit and stops at a start bit.
module srxf_top (
  // Clock and reset
  input wire logic SYS_CLK_IN,
  input wire logic RST_IN,
  // Wishbone slave
  input wire logic WB_CYC_IN,
  input wire logic WB_STB_IN,
  input wire logic WB_WE_IN,
  input wire logic [7:0] WB_ADR_IN,
  input wire logic [3:0] WB_SEL_IN,
  input wire logic [31:0] WB_DAT_IN,
  output logic [31:0] WB_DAT_OUT,
  output logic WB_ACK_OUT,
  // Serial pins
  input wire logic RXD_IN,
  input wire logic SCK_IN,
  // Interrupt
  output logic IRQ_OUT
);
  import srxf_pkg::*;

  // Address match
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  // Trigger level from select code
  function automatic logic [4:0] trig_level(input logic [1:0] sel);
    case (sel)
      2'h0: trig_level = `SRXF_TRG0;
      2'h1: trig_level = `SRXF_TRG1;
      2'h2: trig_level = `SRXF_TRG2;
      default: trig_level = `SRXF_TRG3;
    endcase
  endfunction

  logic rxd_m_ff, rxd_s_ff, sck_m_ff, sck_s_ff;
  logic ack_ff;
  logic [31:0] dat_ff;
  logic [5:0] ctrl_ff;
  logic [15:0] bdiv_ff;
  logic per_ff, rdf_ff, dr_ff;
  logic rdf_seen_ff, rdf_arm_ff, dr_seen_ff, dr_arm_ff;
  logic tmr_run_ff;
  logic [15:0] tmr_div_ff;
  logic [3:0] etu_ff;
  logic [3:0] ists_ff, imsk_ff;
  logic irq_ff;
  logic word_vld, word_perr, start_pulse, stop_pulse, ovr;
  srxf_byte_t word;
  logic [8:0] head;
  logic [4:0] fcnt;

  // Pin synchronisers
  always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      rxd_m_ff <= 1'b1;
      rxd_s_ff <= 1'b1;
      sck_m_ff <= 1'b0;
      sck_s_ff <= 1'b0;
    end else begin
      rxd_m_ff <= RXD_IN;
      rxd_s_ff <= rxd_m_ff;
      sck_m_ff <= SCK_IN;
      sck_s_ff <= sck_m_ff;
    end
  end

  // Control fields
  wire sync_mode = ctrl_ff[`SRXF_CT_SYNC];
  wire [4:0] trig = trig_level(ctrl_ff[`SRXF_CT_TRG_HI:`SRXF_CT_TRG_LO]);
  wire above = fcnt > trig;
  wire below = fcnt < trig;
  wire fempty = (fcnt == 5'h00);

  // Bus decode, transfer completes where ack is high
  wire req = WB_CYC_IN & WB_STB_IN;
  wire acc = req & ack_ff;
  wire wr_acc = acc & WB_WE_IN;
  wire rd_acc = acc & ~WB_WE_IN;
  wire lo_wr = wr_acc & WB_SEL_IN[0];
  wire stat_hit = hit(WB_ADR_IN, `SRXF_ADR_STAT);
  wire data_hit = hit(WB_ADR_IN, `SRXF_ADR_DATA);
  wire ctrl_hit = hit(WB_ADR_IN, `SRXF_ADR_CTRL);
  wire cnt_hit = hit(WB_ADR_IN, `SRXF_ADR_CNT);
  wire bdiv_hit = hit(WB_ADR_IN, `SRXF_ADR_BDIV);
  wire ists_hit = hit(WB_ADR_IN, `SRXF_ADR_ISTS);
  wire imsk_hit = hit(WB_ADR_IN, `SRXF_ADR_IMSK);
  wire pop = rd_acc & data_hit & ~fempty; // see RULE_06
  wire [2:0] stat_val = {per_ff, rdf_ff, dr_ff};

  // Read data select, unmapped reads zero
  wire [31:0] rd_data =
    stat_hit ? {29'h0, stat_val} :
    data_hit ? {24'h0, head[7:0]} :
    ctrl_hit ? {26'h0, ctrl_ff} :
    cnt_hit ? {24'h0, 3'h0, fcnt} : // see RULE_07
    bdiv_hit ? {16'h0, bdiv_ff} :
    ists_hit ? {28'h0, ists_ff} :
    imsk_hit ? {28'h0, imsk_ff} : 32'h0;

  // Ack and read data, one wait state
  always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h0;
    end else begin
      ack_ff <= req & ~ack_ff;
      if (req & ~ack_ff) dat_ff <= WB_WE_IN ? 32'h0 : rd_data;
    end
  end

  // Configuration registers
  always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      ctrl_ff <= `SRXF_CTRL_RST;
      bdiv_ff <= `SRXF_BDIV_RST;
      imsk_ff <= 4'h0;
    end else begin
      if (lo_wr & ctrl_hit) ctrl_ff <= WB_DAT_IN[5:0];
      if (lo_wr & bdiv_hit) bdiv_ff[7:0] <= WB_DAT_IN[7:0];
      if (wr_acc & WB_SEL_IN[1] & bdiv_hit) bdiv_ff[15:8] <= WB_DAT_IN[15:8];
      if (lo_wr & imsk_hit) imsk_ff <= WB_DAT_IN[3:0];
    end
  end

  // Idle timer in bit periods
  wire [3:0] etu_last = `SRXF_DR_ETU - 4'h1;
  wire bit_end = tmr_run_ff & (tmr_div_ff == bdiv_ff);
  wire tmr_fire = bit_end & (etu_ff == etu_last);
  always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      tmr_run_ff <= 1'b0;
      tmr_div_ff <= 16'h0;
      etu_ff <= 4'h0;
    end else if (stop_pulse) begin
      tmr_run_ff <= 1'b1; // see RULE_12
      tmr_div_ff <= 16'h0;
      etu_ff <= 4'h0;
    end else if (start_pulse | tmr_fire) begin
      tmr_run_ff <= 1'b0; // see RULE_12
    end else if (tmr_run_ff) begin
      tmr_div_ff <= bit_end ? 16'h0 : tmr_div_ff + 16'h1;
      etu_ff <= etu_ff + {3'h0, bit_end};
    end
  end

  // Flag set and clear terms
  wire stat_rd = rd_acc & stat_hit;
  wire stat_w0 = lo_wr & stat_hit;
  wire rdf_w0 = stat_w0 & ~WB_DAT_IN[`SRXF_ST_RDF]; // see RULE_11
  wire dr_w0 = stat_w0 & ~WB_DAT_IN[`SRXF_ST_DR]; // see RULE_11
  wire dr_set = tmr_fire & ~sync_mode & below; // see RULE_08 RULE_09
  wire rdf_clr = rdf_arm_ff & below; // see RULE_05
  wire dr_clr = dr_arm_ff & fempty; // see RULE_10
  wire nxt_per = ~sync_mode & ~fempty & head[8]; // see RULE_01 RULE_02
  wire nxt_rdf = above | (rdf_ff & ~rdf_clr); // see RULE_04
  wire nxt_dr = dr_set | (dr_ff & ~dr_clr);

  // Status flags
  always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      per_ff <= 1'b0; // see RULE_03
      rdf_ff <= 1'b0; // see RULE_03
      dr_ff <= 1'b0; // see RULE_03
    end else begin
      per_ff <= nxt_per;
      rdf_ff <= nxt_rdf;
      dr_ff <= nxt_dr;
    end
  end

  // Read-as-1 then write-0 clear sequencing
  always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      rdf_seen_ff <= 1'b0;
      rdf_arm_ff <= 1'b0;
      dr_seen_ff <= 1'b0;
      dr_arm_ff <= 1'b0;
    end else begin
      // Seen only if the value handed to software on this ack showed the flag
      rdf_seen_ff <= nxt_rdf & (rdf_seen_ff | (stat_rd & dat_ff[`SRXF_ST_RDF]));
      rdf_arm_ff <= nxt_rdf & (rdf_arm_ff | (rdf_w0 & rdf_seen_ff)); // see RULE_05
      dr_seen_ff <= nxt_dr & (dr_seen_ff | (stat_rd & dat_ff[`SRXF_ST_DR]));
      dr_arm_ff <= nxt_dr & (dr_arm_ff | (dr_w0 & dr_seen_ff)); // see RULE_10
    end
  end

  // Interrupt events, set wins over write-1 clear
  wire [3:0] ev = {ovr, word_vld & word_perr & ~sync_mode,
                   dr_set & ~dr_ff, above & ~rdf_ff};
  wire [3:0] w1c = (lo_wr & ists_hit) ? WB_DAT_IN[3:0] : 4'h0;
  wire [3:0] nxt_ists = ev | (ists_ff & ~w1c);
  always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      ists_ff <= 4'h0;
      irq_ff <= 1'b0;
    end else begin
      ists_ff <= nxt_ists;
      irq_ff <= |(nxt_ists & imsk_ff);
    end
  end

  // Receiver
  srxf_rx u_rx (
    .clk_in(SYS_CLK_IN),
    .rst_in(RST_IN),
    .rxd_in(rxd_s_ff),
    .sck_in(sck_s_ff),
    .sync_mode_in(sync_mode),
    .par_en_in(ctrl_ff[`SRXF_CT_PEN]),
    .par_odd_in(ctrl_ff[`SRXF_CT_PODD]),
    .bit_div_in(bdiv_ff),
    .word_vld_out(word_vld),
    .word_out(word),
    .perr_out(word_perr),
    .start_out(start_pulse),
    .stop_out(stop_pulse)
  );

  // Receive FIFO, 16 words of data plus parity error
  srxf_fifo u_fifo (
    .clk_in(SYS_CLK_IN),
    .rst_in(RST_IN),
    .push_in(word_vld),
    .wdata_in({word_perr, word}),
    .pop_in(pop),
    .head_out(head),
    .count_out(fcnt),
    .ovr_out(ovr)
  );

  assign WB_ACK_OUT = ack_ff;
  assign WB_DAT_OUT = dat_ff;
  assign IRQ_OUT = irq_ff;

  // Checks
  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (RST_IN);

  property p_per_set;
    (!sync_mode && !fempty && head[8]) |=> per_ff;
  endproperty
  a_per_set: assert property (p_per_set) else $error("parity flag missed"); // see RULE_01

  property p_per_clr;
    (fempty || !head[8]) |=> !per_ff;
  endproperty
  a_per_clr: assert property (p_per_clr) else $error("parity flag stuck"); // see RULE_02

  property p_rst;
    disable iff (1'b0) RST_IN |-> (!per_ff && !rdf_ff && !dr_ff);
  endproperty
  a_rst: assert property (p_rst) else $error("flag set in reset"); // see RULE_03

  property p_rdf_set;
    above |=> rdf_ff;
  endproperty
  a_rdf_set: assert property (p_rdf_set) else $error("rdf not set"); // see RULE_04

  property p_rdf_hold;
    (rdf_ff && !rdf_arm_ff) |=> rdf_ff;
  endproperty
  a_rdf_hold: assert property (p_rdf_hold) else $error("rdf cleared early"); // see RULE_05

  property p_fifo_cap;
    (word_vld && !pop && fcnt == `SRXF_FIFO_DEPTH) |=> fcnt == `SRXF_FIFO_DEPTH;
  endproperty
  a_fifo_cap: assert property (p_fifo_cap) else $error("fifo overfilled"); // see RULE_06

  property p_cnt_rd;
    (req && !ack_ff && !WB_WE_IN && cnt_hit) |=> (WB_DAT_OUT == {27'h0, $past(fcnt)});
  endproperty
  a_cnt_rd: assert property (p_cnt_rd) else $error("count read wrong"); // see RULE_07

  property p_dr_set;
    (tmr_fire && !sync_mode && below) |=> dr_ff;
  endproperty
  a_dr_set: assert property (p_dr_set) else $error("dr not set"); // see RULE_08

  property p_dr_sync;
    $rose(dr_ff) |-> !$past(sync_mode);
  endproperty
  a_dr_sync: assert property (p_dr_sync) else $error("dr set in sync mode"); // see RULE_09

  property p_dr_hold;
    (dr_ff && !(dr_arm_ff && fempty)) |=> dr_ff;
  endproperty
  a_dr_hold: assert property (p_dr_hold) else $error("dr cleared early"); // see RULE_10

  property p_w1_noset;
    (!dr_ff && !dr_set) |=> !dr_ff;
  endproperty
  a_w1_noset: assert property (p_w1_noset) else $error("dr set by write"); // see RULE_11

  property p_tmr_cancel;
    (start_pulse && !stop_pulse) |=> !tmr_run_ff ##1 !dr_set;
  endproperty
  a_tmr_cancel: assert property (p_tmr_cancel) else $error("timer ran on"); // see RULE_12

  property p_rdf_clr;
    (rdf_arm_ff && below) |=> !rdf_ff;
  endproperty
  a_rdf_clr: assert property (p_rdf_clr) else $error("rdf not cleared"); // see RULE_05

  property p_dr_clr;
    (dr_arm_ff && fempty && !dr_set) |=> !dr_ff;
  endproperty
  a_dr_clr: assert property (p_dr_clr) else $error("dr not cleared"); // see RULE_10

  property p_ovr_evt;
    (word_vld && fcnt == `SRXF_FIFO_DEPTH) |=> ists_ff[`SRXF_IRQ_OVR];
  endproperty
  a_ovr_evt: assert property (p_ovr_evt) else $error("overrun event missed"); // see RULE_06

  property p_ack;
    (req && !ack_ff) |=> ack_ff ##1 !ack_ff;
  endproperty
  a_ack: assert property (p_ack) else $error("ack timing wrong");

  c_rdf: cover property ($rose(rdf_ff));
  c_dr: cover property ($rose(dr_ff));
  c_per: cover property ($rose(per_ff));
  c_irq: cover property ($rose(irq_ff));
  c_ovr: cover property (ovr);
endmodule // srxf_top
`default_nettype wire

// ==== verif/srxf_far_tx.sv ====
`timescale 1ns/1ps
`default_nettype none
module srxf_far_tx (
  // Clock
  input wire logic clk_in,
  // Line outputs
  output logic rxd_out,
  output logic sck_out
);
  int bit_clks = 17;
  // Line idles at mark, serial clock stands still low
  initial begin
    rxd_out = 1'b1;
    sck_out = 1'b0;
  end
  // Async frame: start, 8 data LSB first, parity or mark, stop; bad flips parity
  task automatic send(input logic [7:0] b, input logic par_en, input logic odd,
                      input logic bad);
    logic [10:0] fr;
    fr = {1'b1, par_en ? (^b ^ odd ^ bad) : 1'b1, b, 1'b0};
    for (int i = 0; i < 11; i++) begin
      @(posedge clk_in);
      rxd_out <= fr[i];
      repeat (bit_clks - 1) @(posedge clk_in);
    end
  endtask
  // Clocked word: 8 bits LSB first, each taken on a clock rise
  task automatic send_sync(input logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_in);
      rxd_out <= b[i];
      repeat (8) @(posedge clk_in);
      sck_out <= 1'b1;
      repeat (8) @(posedge clk_in);
      sck_out <= 1'b0;
    end
    @(posedge clk_in);
    rxd_out <= 1'b1;
  endtask
endmodule // srxf_far_tx
`default_nettype wire

// ==== verif/tb_serial_rx_fifo_status_flags.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "srxf_map.svh"
module tb_serial_rx_fifo_status_flags;
  logic clk = 1'b0;
  logic rst = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h00000000;
  logic [31:0] rdat;
  logic ack;
  logic irq;
  logic rxd;
  logic sck;
  int n_errors = 0;
  int checks_done = 0;
  int trg[4] = '{`SRXF_TRG0, `SRXF_TRG1, `SRXF_TRG2, `SRXF_TRG3};
  // 125 MHz clock
  always #4 clk = ~clk;
  srxf_top srxf_top_inst (
    .SYS_CLK_IN(clk), .RST_IN(rst), .WB_CYC_IN(cyc), .WB_STB_IN(stb),
    .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(wdat),
    .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack), .RXD_IN(rxd), .SCK_IN(sck), .IRQ_OUT(irq)
  );
  srxf_far_tx srxf_far_tx_inst (.clk_in(clk), .rxd_out(rxd), .sck_out(sck));
  // Compare and report
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One classic Wishbone cycle, held until ack
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hF;
    // Only the watchdog ends a wait for ack
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic do_reset();
    @(posedge clk);
    rst <= 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Watchdog
  initial begin
    repeat (40000) @(posedge clk);
    n_errors++;
    print_verdict();
  end
  // Main sequence
  initial begin
    do_reset();
    rd(`SRXF_ADR_STAT, 32'h0); // Flags low
    rd(`SRXF_ADR_CNT, 32'h0); // Empty count
    rd(`SRXF_ADR_CTRL, 32'h0);
    rd(`SRXF_ADR_BDIV, 32'h10);
    rd(8'h20, 32'h0);
    wr(`SRXF_ADR_STAT, 32'h7);
    rd(`SRXF_ADR_STAT, 32'h0); // Ones set nothing
    // Parity flag follows head word; trigger 4, even parity
    wr(`SRXF_ADR_CTRL, 32'h12);
    srxf_far_tx_inst.send(8'hA5, 1'b1, 1'b0, 1'b1);
    srxf_far_tx_inst.send(8'h3C, 1'b1, 1'b0, 1'b0);
    rd(`SRXF_ADR_STAT, 32'h4); // Bad head
    rd(`SRXF_ADR_CNT, 32'h2); // Two held
    rd(`SRXF_ADR_DATA, 32'hA5);
    rd(`SRXF_ADR_STAT, 32'h0); // Good head
    // Idle timeout near 15 bit periods of 17 clocks
    repeat (190) @(posedge clk);
    rd(`SRXF_ADR_STAT, 32'h0); // Too early
    repeat (100) @(posedge clk);
    rd(`SRXF_ADR_STAT, 32'h1); // Timed out
    wr(`SRXF_ADR_STAT, 32'hFF);
    rd(`SRXF_ADR_STAT, 32'h1); // Ones clear nothing
    wr(`SRXF_ADR_STAT, 32'h0);
    rd(`SRXF_ADR_STAT, 32'h1); // Word left
    rd(`SRXF_ADR_DATA, 32'h3C);
    rd(`SRXF_ADR_STAT, 32'h0); // Drained
    // Sticky events, mask and interrupt
    rd(`SRXF_ADR_ISTS, 32'h6);
    wr(`SRXF_ADR_IMSK, 32'h4);
    repeat (2) @(posedge clk);
    chk(irq, 1'b1);
    wr(`SRXF_ADR_ISTS, 32'h4);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0);
    rd(`SRXF_ADR_ISTS, 32'h2);
    // Every trigger select: boundary, set, clear discipline
    for (int s = 0; s < 4; s++) begin
      do_reset();
      wr(`SRXF_ADR_CTRL, 32'(s) << 4);
      for (int k = 0; k < trg[s]; k++) srxf_far_tx_inst.send(8'h10 + 8'(k), 1'b0, 1'b0, 1'b0);
      rd(`SRXF_ADR_STAT, 32'h0); // Equal is not above
      srxf_far_tx_inst.send(8'h55, 1'b0, 1'b0, 1'b0);
      rd(`SRXF_ADR_STAT, 32'h2); // Above trigger
      rd(`SRXF_ADR_CNT, 32'(trg[s] + 1)); // Fill count
      wr(`SRXF_ADR_STAT, 32'h0);
      rd(`SRXF_ADR_DATA, 32'h10);
      rd(`SRXF_ADR_STAT, 32'h2); // At trigger
      rd(`SRXF_ADR_DATA, trg[s] > 1 ? 32'h11 : 32'h55);
      rd(`SRXF_ADR_STAT, 32'h0); // Below trigger
    end
    // Fill past 16 words: overrun event
    repeat (4) srxf_far_tx_inst.send(8'h66, 1'b0, 1'b0, 1'b0);
    rd(`SRXF_ADR_CNT, 32'h10); // Full at 16
    rd(`SRXF_ADR_ISTS, 32'h9);
    // Async word arms idle timer, clocked mode before it runs out
    do_reset();
    wr(`SRXF_ADR_CTRL, 32'h10);
    srxf_far_tx_inst.send(8'h5A, 1'b0, 1'b0, 1'b0);
    wr(`SRXF_ADR_CTRL, 32'h11);
    srxf_far_tx_inst.send_sync(8'hC3);
    repeat (400) @(posedge clk);
    rd(`SRXF_ADR_CNT, 32'h2); // Two words
    rd(`SRXF_ADR_STAT, 32'h0); // Never set
    rd(`SRXF_ADR_DATA, 32'h5A);
    rd(`SRXF_ADR_DATA, 32'hC3);
    print_verdict();
  end
endmodule // tb_serial_rx_fifo_status_flags
`default_nettype wire
